// ===== test/csp_properties.sv
// Port checks of the clock source and prescaler block
`timescale 1ns/10ps
module csp_properties #(
  parameter logic [7:0] FACTORY_TRIM = 8'h80  // Factory calibration value
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       sleep_req,
  input wire logic       cpu_halt,
  input wire logic       sys_clock,
  input wire logic       sys_active_edge,
  input wire logic       exec_enable,
  input wire logic       cpu_clock_en,
  input wire logic       converter_clock_en,
  input wire logic       trim_range_bit,
  input wire logic [6:0] trim_fine_bits,
  input wire logic       crystal_osc_enable,
  input wire logic       port_b_bit4_gpio_en,
  input wire logic       port_b_bit5_gpio_en,
  input wire logic       clock_output_pin_o,
  input wire logic       clock_output_pin_oe
);
  // One domain; reset cancels checks except those about reset itself
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_NO_OUT_IN_RESET: assert property (disable iff (1'b0)
    rst |-> !clock_output_pin_oe) else $error("clock output driven in reset");
  AST_TRIM_RESET: assert property (disable iff (1'b0)
    rst |-> {trim_range_bit, trim_fine_bits} == FACTORY_TRIM) else $error("trim reset wrong");
  AST_OUT_IS_SYS: assert property (
    clock_output_pin_oe |-> clock_output_pin_o == sys_clock) else $error("clock out not sys");
  AST_EDGE_PULSE: assert property (
    $rose(sys_clock) |-> sys_active_edge ##1 !sys_active_edge) else $error("edge pulse bad");
  AST_EDGE_ONLY_RISE: assert property (
    sys_active_edge |-> sys_clock && !$past(sys_clock)) else $error("stray edge pulse");
  AST_CRYSTAL_PINS: assert property (
    crystal_osc_enable |-> !port_b_bit4_gpio_en && !port_b_bit5_gpio_en && !clock_output_pin_oe)
    else $error("crystal pins not taken");
  AST_HALT_GATES: assert property (
    cpu_halt |=> !cpu_clock_en) else $error("cpu clock not halted");
  AST_CONV_RUNS: assert property (
    cpu_clock_en |-> converter_clock_en) else $error("converter clock stopped");
  AST_SLEEP_STOPS: assert property (
    exec_enable && sleep_req |-> ##[1:2] !exec_enable) else $error("sleep ignored");
  AST_STARTUP_HOLD: assert property (
    $fell(exec_enable) |-> !exec_enable [*8]) else $error("start-up too short");
  AST_READ_IDLE: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside slot");
  // Main scenarios reached
  cover property ($rose(clock_output_pin_oe));
  cover property (sys_active_edge);
  cover property ($rose(exec_enable));
endmodule // csp_properties

bind csp_clock_source_prescaler csp_properties #(.FACTORY_TRIM(FACTORY_TRIM)) chk_u (
  .clk, .rst, .reg_rd, .reg_rdata, .sleep_req, .cpu_halt, .sys_clock, .sys_active_edge,
  .exec_enable, .cpu_clock_en, .converter_clock_en, .trim_range_bit, .trim_fine_bits,
  .crystal_osc_enable, .port_b_bit4_gpio_en, .port_b_bit5_gpio_en, .clock_output_pin_o,
  .clock_output_pin_oe);

// ===== test/csp_source_model.sv
// Free-running clock source standing at the far side of the block
`timescale 1ns/10ps
module csp_source_model #(
  parameter int HALF = 300  // Half period in ns, at least three clk cycles
) (
  output logic src  // Oscillator or clock pin level
);
  // Oscillators run free; no edge lands on a rising clk edge with these periods
  initial begin
    src = 1'b0;
    forever #(HALF) src = ~src;
  end
endmodule // csp_source_model

// ===== test/test_clock_source_prescaler.sv
// Self-checking bench for the clock source and prescaler block
`timescale 1ns/10ps
module test_clock_source_prescaler;
  import csp_pkg::*;
  logic       clk = 1'b0;                    // Block clock, 100 ns
  logic       rst = 1'b0;                    // Async reset, raised at time 0
  logic [7:0] reg_addr = 8'h00;              // Register address
  logic [7:0] reg_wdata = 8'h00;             // Write data
  logic [7:0] reg_rdata;                     // Read data
  logic [3:0] source_select_fuses = 4'h2;    // Fuse code
  logic       reg_wr = 1'b0, reg_rd = 1'b0, clock_output_fuse = 1'b1;
  logic       sleep_req = 1'b0, wake_req = 1'b0, cpu_halt = 1'b0;
  logic       external_clock_input, pll_clock_in, rc_clock_in, wdosc_clock_in;
  logic       crystal_clock_in, sys_clock, sys_active_edge, exec_enable, cpu_clock_en;
  logic       converter_clock_en, fast_peripheral_clock, trim_range_bit, crystal_osc_enable;
  logic       port_b_bit4_gpio_en, port_b_bit5_gpio_en, clock_output_pin_o, clock_output_pin_oe;
  logic [6:0] trim_fine_bits;                // Trim fine field
  int         failures = 0;                  // Mismatches
  int         check_count = 0;               // Comparisons
  int         cycles = 0;                    // Timeout counter
  int         seed = 60685;                  // Fixed seed
  int         n, i, hi;                      // Counters
  logic [7:0] exp_q[$];                      // Expected read data, oldest first
  logic       rd_seen = 1'b0;                // Read taken at last edge
  logic [7:0] v;                             // Random trim value
  logic       fo, xt, oe, last;              // Per-case expectations

  always #50 clk = ~clk;

  // Far-side sources; RC period is exactly 8 clk so divided periods are exact
  csp_source_model ext_u (.src(external_clock_input));
  csp_source_model pll_u (.src(pll_clock_in));
  csp_source_model #(.HALF(400)) rc_u (.src(rc_clock_in));
  csp_source_model #(.HALF(500)) wd_u (.src(wdosc_clock_in));
  csp_source_model #(.HALF(300)) xt_u (.src(crystal_clock_in));

  csp_clock_source_prescaler #(.FACTORY_TRIM(8'h80)) dut_u (
    .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .source_select_fuses,
    .clock_output_fuse, .external_clock_input, .pll_clock_in, .rc_clock_in, .wdosc_clock_in,
    .crystal_clock_in, .sleep_req, .wake_req, .cpu_halt, .sys_clock, .sys_active_edge,
    .exec_enable, .cpu_clock_en, .converter_clock_en, .fast_peripheral_clock,
    .trim_range_bit, .trim_fine_bits, .crystal_osc_enable, .port_b_bit4_gpio_en,
    .port_b_bit5_gpio_en, .clock_output_pin_o, .clock_output_pin_oe);

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // One strobe cycle; a read notes its expected data for the monitor
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    if (!wr) exp_q.push_back(d);
  endtask

  task automatic idle(input int k);
    repeat (k) begin
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
    end
  endtask

  // Reset with given fuses, then count cycles until execution starts
  task automatic boot(input logic [3:0] c, input logic f);
    rst <= 1'b1;
    source_select_fuses <= c;
    clock_output_fuse <= f;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    n = 0;
    while (exec_enable !== 1'b1 && n < 8000) begin
      @(posedge clk);
      n++;
    end
  endtask

  // Cycles since the previous active edge of the divided clock
  task automatic wait_edge();
    n = 0;
    hi = 0;
    do begin
      @(posedge clk);
      n++;
      if (clock_output_pin_o === 1'b1) hi++;
    end while (sys_active_edge !== 1'b1 && n < 500);
  endtask

  // Read monitor takes the oldest note when read data appear; also the hang limit
  always @(posedge clk) begin
    rd_seen <= reg_rd;
    cycles <= cycles + 1;
    if (rd_seen && exp_q.size() > 0) check("rdata", reg_rdata, exp_q.pop_front());
    if (cycles > 90000) begin
      failures++;
      results();
    end
  end

  initial begin
    // Every fuse code, clock-out fuse random; crystal start-up is the long one
    for (i = 0; i < 16; i++) begin
      fo = 1'($random(seed));
      boot(i[3:0], fo);
      xt = i[3] | i[2];
      oe = !fo && !xt;
      repeat (3) @(posedge clk);
      check("xtal", {7'h00, crystal_osc_enable}, {7'h00, xt});
      check("pb4", {7'h00, port_b_bit4_gpio_en}, {7'h00, !(xt || i == 0)});
      check("oe", {7'h00, clock_output_pin_oe}, {7'h00, oe});
      check("pb5", {7'h00, port_b_bit5_gpio_en}, {7'h00, !(xt || oe)});
      // Shortest start-up: (edges - 1) source periods of 6 clk each
      check("su", {7'h00, n >= (i[3] ? 1530 : i[2] ? 6138 : 30)}, 8'h01);
    end
    // Internal RC with clock output; register traffic back to back
    boot(CSP_FUSE_RC, 1'b0);
    v = 8'($random(seed));  // Any trim allowed: no memory write runs here
    bus(0, CSP_OFS_STATUS, 8'hA2);
    bus(0, CSP_OFS_TRIM, 8'h80);
    bus(1, CSP_OFS_TRIM, v);
    bus(0, CSP_OFS_TRIM, v);
    bus(0, 8'h00, 8'h00);
    bus(1, CSP_OFS_PRESCALE, 8'h83);
    bus(0, CSP_OFS_PRESCALE, 8'h00);
    bus(1, CSP_OFS_PRESCALE, 8'h03);
    bus(0, CSP_OFS_PRESCALE, 8'h00);
    bus(1, CSP_OFS_PRESCALE, 8'h80);
    bus(0, CSP_OFS_PRESCALE, 8'h80);
    bus(1, CSP_OFS_PRESCALE, 8'h03);
    bus(0, CSP_OFS_PRESCALE, 8'h03);
    // Unlock lapses after its window, so this select is refused
    bus(1, CSP_OFS_PRESCALE, 8'h80);
    idle(6);
    bus(1, CSP_OFS_PRESCALE, 8'h01);
    bus(0, CSP_OFS_PRESCALE, 8'h03);
    idle(2);
    check("trim", {trim_range_bit, trim_fine_bits}, v);
    // Divide by 8 of an 8-cycle source gives 64 cycles between active edges
    repeat (3) wait_edge();
    wait_edge();
    check("period", n[7:0], 8'h40);
    check("pin high", hi[7:0], 8'h20);
    check("pin oe", {7'h00, clock_output_pin_oe}, 8'h01);
    // PLL clock keeps toggling for peripherals
    n = 0;
    last = fast_peripheral_clock;
    repeat (40) begin
      @(posedge clk);
      if (fast_peripheral_clock !== last) n++;
      last = fast_peripheral_clock;
    end
    check("fpc", {7'h00, n > 0}, 8'h01);
    // Halt stops CPU clock only, then sleep and wake through a fresh start-up
    cpu_halt <= 1'b1;
    idle(2);
    check("halt", {6'h00, cpu_clock_en, converter_clock_en}, 8'h01);
    cpu_halt <= 1'b0;
    sleep_req <= 1'b1;
    idle(1);
    sleep_req <= 1'b0;
    idle(10);
    wake_req <= 1'b1;
    idle(1);
    wake_req <= 1'b0;
    n = 0;
    while (exec_enable !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    check("wake", {7'h00, n >= 40 && n < 2000}, 8'h01);
    results();
  end
endmodule // test_clock_source_prescaler

// ===== verilog/csp_clock_source_prescaler.sv
// Clock source select, oscillator trim, prescaler and clock output
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
module csp_clock_source_prescaler #(
  parameter logic [7:0] FACTORY_TRIM = 8'h80  // Factory calibration value
) (
  input  wire logic       clk,                    // 10 MHz block clock
  input  wire logic       rst,                    // Async reset, high
  input  wire logic [7:0] reg_addr,               // Register address
  input  wire logic [7:0] reg_wdata,              // Register write data
  input  wire logic       reg_wr,                 // Write strobe
  input  wire logic       reg_rd,                 // Read strobe
  output logic      [7:0] reg_rdata,              // Read data, cycle after
  input  wire logic [3:0] source_select_fuses,    // Source select fuses
  input  wire logic       clock_output_fuse,      // Clock output fuse
  input  wire logic       external_clock_input,   // External clock pin
  input  wire logic       pll_clock_in,           // PLL output
  input  wire logic       rc_clock_in,            // Internal RC oscillator
  input  wire logic       wdosc_clock_in,         // 128 kHz oscillator
  input  wire logic       crystal_clock_in,       // Crystal amplifier out
  input  wire logic       sleep_req,              // Enter power-down
  input  wire logic       wake_req,               // Wake-up event
  input  wire logic       cpu_halt,               // Halt CPU clock only
  output logic            sys_clock,              // Divided system clock
  output logic            sys_active_edge,        // Rising edge pulse
  output logic            exec_enable,            // Instruction execution
  output logic            cpu_clock_en,           // CPU clock gate
  output logic            converter_clock_en,     // Converter clock gate
  output logic            fast_peripheral_clock,  // PLL clock to peripherals
  output logic            trim_range_bit,         // RC range select
  output logic      [6:0] trim_fine_bits,         // RC fine tune
  output logic            crystal_osc_enable,     // Crystal amplifier on
  output logic            port_b_bit4_gpio_en,    // Bit 4 left to port
  output logic            port_b_bit5_gpio_en,    // Bit 5 left to port
  output logic            clock_output_pin_o,     // Clock output level
  output logic            clock_output_pin_oe     // Clock output drive
);
  import csp_pkg::*;

  // Source input index order in the synchroniser
  localparam int NSRC = 5;

  logic [NSRC-1:0] src_raw;      // Raw source levels
  logic [NSRC-1:0] sync1_q;      // First stage, read only by second
  logic [NSRC-1:0] sync2_q;      // Second stage
  logic [NSRC-1:0] sync3_q;      // Third stage
  logic [NSRC-1:0] lvl_q;        // Filtered source levels
  logic [NSRC-1:0] lvl_prev_q;   // Previous filtered levels
  logic [NSRC-1:0] rise;         // Rising edge per source
  logic            fuses_ok_q;   // Fuses captured after reset
  logic [3:0]      fuse_sel_q;   // Captured source code
  logic            fuse_out_q;   // Captured clock output fuse
  csp_src_t        src_kind;     // Decoded source kind
  logic            is_crystal;   // Any crystal source
  logic            src_lvl;      // Selected source level
  logic            src_edge;     // Selected source rising edge
  logic            ce_q;         // Prescale change enable
  logic [2:0]      ce_cnt_q;     // Change enable lifetime
  logic [3:0]      sel_q;        // Prescale select as written
  logic [3:0]      act_sel_q;    // Prescale exponent in effect
  logic            pend_q;       // New select waiting to apply
  logic [7:0]      div_cnt_q;    // Source edges in half period
  logic [7:0]      half_m1;      // Half period minus one
  logic            sys_clk_q;    // Divided clock
  logic            edge_q;       // Active edge pulse
  logic            apply_now;    // Boundary where select switches
  logic            sys_rise;     // Divided clock about to rise
  logic [7:0]      trim_q;       // Oscillator trim
  csp_run_t        run_q;        // Run state
  logic [11:0]     su_cnt_q;     // Start-up edges counted
  logic [11:0]     su_load;      // Start-up length for source
  logic            cpu_en_q;     // CPU clock gate
  logic            conv_en_q;    // Converter clock gate
  logic            clock_output_pin_on;      // Clock output permitted
  logic            clock_output_pin_oe_q;    // Clock output enable
  logic [7:0]      rdata_q;      // Read data
  logic            wr_pre;       // Write to prescale register
  logic            wr_trim;      // Write to trim register

  assign src_raw = {crystal_clock_in, wdosc_clock_in, rc_clock_in,
                    pll_clock_in, external_clock_input};

  // Three-stage synchroniser; a change counts once stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= src_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Filtered levels and their previous value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lvl_q      <= '0;
      lvl_prev_q <= '0;
    end else begin
      for (int i = 0; i < NSRC; i++) begin
        if (sync2_q[i] == sync3_q[i]) begin
          lvl_q[i] <= sync3_q[i];
        end
      end
      lvl_prev_q <= lvl_q;
    end
  end

  assign rise = lvl_q & ~lvl_prev_q;

  // Fuses are straps: caught on the first edge after reset release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fuses_ok_q <= 1'b0;
      fuse_sel_q <= CSP_FUSE_EXT;
      fuse_out_q <= 1'b1;
    end else if (!fuses_ok_q) begin
      fuses_ok_q <= 1'b1;
      fuse_sel_q <= source_select_fuses;
      fuse_out_q <= clock_output_fuse;
    end
  end

  // Source decode from the captured code
  always_comb begin
    src_kind = CSP_SRC_EXT;
    if (fuse_sel_q[3]) begin
      src_kind = csp_src_t'(4'(CSP_SRC_XB0) + {2'b00, fuse_sel_q[2:1]});
    end else if (fuse_sel_q[2]) begin
      src_kind = CSP_SRC_LFX;
    end else begin
      unique case (fuse_sel_q)
        CSP_FUSE_PLL:   src_kind = CSP_SRC_PLL;
        CSP_FUSE_RC:    src_kind = CSP_SRC_RC;
        CSP_FUSE_WDOSC: src_kind = CSP_SRC_WDOSC;
        default:        src_kind = CSP_SRC_EXT;
      endcase
    end
  end

  assign is_crystal = fuse_sel_q[3] | fuse_sel_q[2];

  // Selected source level and edge, start-up length per source
  always_comb begin
    src_lvl  = lvl_q[4];
    src_edge = rise[4];
    su_load  = CSP_SU_XTAL;
    unique case (src_kind)
      CSP_SRC_EXT: begin
        src_lvl  = lvl_q[0];
        src_edge = rise[0];
        su_load  = CSP_SU_CLOCK;
      end
      CSP_SRC_PLL: begin
        src_lvl  = lvl_q[1];
        src_edge = rise[1];
        su_load  = CSP_SU_CLOCK;
      end
      CSP_SRC_RC: begin
        src_lvl  = lvl_q[2];
        src_edge = rise[2];
        su_load  = CSP_SU_CLOCK;
      end
      CSP_SRC_WDOSC: begin
        src_lvl  = lvl_q[3];
        src_edge = rise[3];
        su_load  = CSP_SU_CLOCK;
      end
      CSP_SRC_LFX: begin
        su_load  = CSP_SU_LFX;
      end
      default: begin
        su_load  = CSP_SU_XTAL;
      end
    endcase
  end

  assign wr_pre  = reg_wr && (reg_addr == CSP_OFS_PRESCALE);
  assign wr_trim = reg_wr && (reg_addr == CSP_OFS_TRIM);

  // Change enable: a write with the other bits all zero sets or clears it; a select write uses it up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ce_q     <= 1'b0;
      ce_cnt_q <= '0;
    end else if (wr_pre && (reg_wdata[CSP_CE_BIT-1:0] == 7'h00)) begin
      ce_q     <= reg_wdata[CSP_CE_BIT];
      // A clearing write must not leave the countdown armed to reopen
      ce_cnt_q <= reg_wdata[CSP_CE_BIT] ? CSP_CE_WINDOW : 3'h0;
    end else if (wr_pre && ce_q && !reg_wdata[CSP_CE_BIT]) begin
      ce_q     <= 1'b0;  // Used up by the select write
      ce_cnt_q <= '0;
    end else if (ce_cnt_q != 3'h0) begin
      ce_cnt_q <= ce_cnt_q - 3'h1;
      ce_q     <= (ce_cnt_q != 3'h1);
    end
  end

  // Select write accepted only inside the open window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_q <= CSP_PRESCALE_RST;
    end else if (wr_pre && ce_q && !reg_wdata[CSP_CE_BIT]) begin
      sel_q <= reg_wdata[CSP_SEL_MSB:0];
    end
  end

  // Half period of the divided clock in source edges, less one
  assign half_m1 = 8'(9'(9'h001 << act_sel_q) >> 1) - 8'h01;

  assign sys_rise  = (act_sel_q == 4'h0) ? src_edge :
                     (src_edge && !sys_clk_q && (div_cnt_q == half_m1));
  // A new setting takes over at the next rising edge, ending the old period
  assign apply_now = pend_q && (sys_rise || run_q == CSP_SLEEP);

  // Pending select and the exponent in effect
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_q    <= 1'b0;
      act_sel_q <= CSP_PRESCALE_RST;
    end else if (wr_pre && ce_q && !reg_wdata[CSP_CE_BIT]) begin
      pend_q    <= 1'b1;
    end else if (apply_now) begin
      pend_q    <= 1'b0;
      act_sel_q <= (sel_q > CSP_PRESCALE_MAX) ? CSP_PRESCALE_MAX : sel_q;
    end
  end

  // Divider; frozen low while asleep. PLL as source passes here too
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt_q <= '0;
      sys_clk_q <= 1'b0;
      edge_q    <= 1'b0;
    end else if (run_q == CSP_SLEEP) begin
      div_cnt_q <= '0;
      sys_clk_q <= 1'b0;
      edge_q    <= 1'b0;
    end else if (apply_now) begin
      div_cnt_q <= '0;  // Fresh new period starts on this edge
      sys_clk_q <= 1'b1;
      edge_q    <= 1'b1;
    end else if (act_sel_q == 4'h0) begin
      sys_clk_q <= src_lvl;  // Divide by one
      edge_q    <= src_edge;
    end else if (src_edge) begin
      edge_q <= sys_rise;
      if (div_cnt_q == half_m1) begin
        div_cnt_q <= '0;
        sys_clk_q <= !sys_clk_q;
      end else begin
        div_cnt_q <= div_cnt_q + 8'h01;
      end
    end else begin
      edge_q <= 1'b0;
    end
  end

  // Trim register; factory value is the reset constant
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trim_q <= FACTORY_TRIM;
    end else if (wr_trim) begin
      trim_q <= reg_wdata;
    end
  end

  // Range bit and fine code go straight to the analog oscillator
  assign trim_range_bit = trim_q[7];
  assign trim_fine_bits = trim_q[6:0];

  // Run state: start-up counted in edges of the chosen source
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_q    <= CSP_STARTUP;
      su_cnt_q <= '0;
    end else begin
      unique case (run_q)
        CSP_STARTUP: begin
          if (!fuses_ok_q) begin
            su_cnt_q <= '0;
          end else if (su_cnt_q == su_load) begin
            run_q <= CSP_RUN;
          end else if (src_edge) begin
            su_cnt_q <= su_cnt_q + 12'h001;
          end
        end
        CSP_RUN: begin
          if (sleep_req) begin
            run_q <= CSP_SLEEP;
          end
        end
        CSP_SLEEP: begin
          if (wake_req) begin
            run_q    <= CSP_STARTUP;
            su_cnt_q <= '0;
          end
        end
      endcase
    end
  end

  // Clock gates; the converter keeps its clock while the CPU halts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_en_q  <= 1'b0;
      conv_en_q <= 1'b0;
    end else begin
      cpu_en_q  <= (run_q == CSP_RUN) && !cpu_halt;
      conv_en_q <= (run_q == CSP_RUN);
    end
  end

  // Crystal pins are not usable for clock output
  assign clock_output_pin_on = !fuse_out_q && !is_crystal;

  // Output enable is a constant 0 under reset, so nothing drives then
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clock_output_pin_oe_q <= 1'b0;
    end else begin
      clock_output_pin_oe_q <= fuses_ok_q && clock_output_pin_on;
    end
  end

  // Read path; data stands one cycle only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= CSP_RDATA_RST;
    end else if (reg_rd) begin
      unique case (reg_addr)
        CSP_OFS_PRESCALE: rdata_q <= {ce_q, 3'h0, sel_q};
        CSP_OFS_TRIM:     rdata_q <= trim_q;
        CSP_OFS_STATUS:   rdata_q <= {run_q == CSP_RUN, is_crystal, clock_output_pin_on,
                                      pend_q, fuse_sel_q};
        default:          rdata_q <= 8'h00;  // Unmapped reads zero
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata             = rdata_q;
  assign sys_clock             = sys_clk_q;
  assign sys_active_edge       = edge_q;
  assign exec_enable           = (run_q == CSP_RUN);
  assign cpu_clock_en          = cpu_en_q;
  assign converter_clock_en    = conv_en_q;
  assign fast_peripheral_clock = lvl_q[1];
  assign crystal_osc_enable    = fuses_ok_q && is_crystal && (run_q != CSP_SLEEP);
  assign port_b_bit4_gpio_en   = !(fuses_ok_q && (is_crystal || src_kind == CSP_SRC_EXT));
  assign port_b_bit5_gpio_en   = !(fuses_ok_q && is_crystal) && !clock_output_pin_oe_q;
  assign clock_output_pin_o    = sys_clk_q;
  assign clock_output_pin_oe   = clock_output_pin_oe_q;

endmodule  // csp_clock_source_prescaler

// ===== verilog/csp_pkg.sv
// Constants and types shared by the clock source and prescaler block
package csp_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] CSP_OFS_PRESCALE = 8'h28;
  localparam logic [7:0] CSP_OFS_TRIM     = 8'h31;
  localparam logic [7:0] CSP_OFS_STATUS   = 8'h32;

  // Field positions in the prescale control register
  localparam int CSP_CE_BIT  = 7;
  localparam int CSP_SEL_MSB = 3;

  // Reset values
  localparam logic [3:0] CSP_PRESCALE_RST = 4'h0;
  localparam logic [7:0] CSP_RDATA_RST    = 8'h00;

  // Largest prescale exponent in effect; higher codes clamp to it
  localparam logic [3:0] CSP_PRESCALE_MAX = 4'h8;

  // Block clock cycles the change enable stays open
  localparam logic [2:0] CSP_CE_WINDOW = 3'h4;

  // Fuse codes of the source select field (raw pin levels)
  localparam logic [3:0] CSP_FUSE_EXT   = 4'h0;
  localparam logic [3:0] CSP_FUSE_PLL   = 4'h1;
  localparam logic [3:0] CSP_FUSE_RC    = 4'h2;
  localparam logic [3:0] CSP_FUSE_WDOSC = 4'h3;

  // Start-up delays in edges of the selected source
  localparam logic [11:0] CSP_SU_CLOCK = 12'h006;
  localparam logic [11:0] CSP_SU_LFX   = 12'h400;
  localparam logic [11:0] CSP_SU_XTAL  = 12'h100;

  // Selected clock source kind
  typedef enum logic [3:0] {
    CSP_SRC_EXT, CSP_SRC_PLL, CSP_SRC_RC, CSP_SRC_WDOSC, CSP_SRC_LFX,
    CSP_SRC_XB0, CSP_SRC_XB1, CSP_SRC_XB2, CSP_SRC_XB3
  } csp_src_t;

  // Run state of the clock generator
  typedef enum logic [1:0] {CSP_STARTUP, CSP_RUN, CSP_SLEEP} csp_run_t;

endpackage
